// [core/sfhi_pkg.sv]
// Shared constants and types of the serial flash host interface.
// Assumes the main flash array is an external macro with byte access.
package sfhi_pkg;
   localparam int PAGE_COUNT = 4096;
   localparam int BUF_BYTES = 528;
   localparam int SEC_USER_BYTES = 64;
   localparam int SECTOR_COUNT = 16;
   localparam logic [9:0] PAGE_LAST_STD = 10'h20F;
   localparam logic [9:0] PAGE_LAST_BIN = 10'h1FF;
   localparam logic [11:0] BLOCK_PAGE_MASK = 12'hFF8;
   localparam logic [11:0] SECTOR_PAGE_MASK = 12'hF00;
   localparam logic [12:0] PAGES_PAGE = 13'h0001;
   localparam logic [12:0] PAGES_BLOCK = 13'h0008;
   localparam logic [12:0] PAGES_SECTOR = 13'h0100;
   localparam logic [12:0] PAGES_CHIP = 13'h1000;
   localparam logic [7:0] FILL_BYTE = 8'hFF;
   localparam int STAT_READY_BIT = 7;
   localparam int STAT_PROT_BIT = 1;
   localparam int STAT_BIN_BIT = 0;
   localparam logic [7:0] OP_STATUS = 8'hD7;
   localparam logic [7:0] OP_ID = 8'h9F;
   localparam logic [7:0] OP_BUF1_WR = 8'h84;
   localparam logic [7:0] OP_BUF2_WR = 8'h87;
   localparam logic [7:0] OP_BUF1_RD = 8'hD4;
   localparam logic [7:0] OP_BUF2_RD = 8'hD6;
   localparam logic [7:0] OP_PROG1 = 8'h83;
   localparam logic [7:0] OP_PROG2 = 8'h86;
   localparam logic [7:0] OP_XFER1 = 8'h53;
   localparam logic [7:0] OP_XFER2 = 8'h55;
   localparam logic [7:0] OP_ERASE_PAGE = 8'h81;
   localparam logic [7:0] OP_ERASE_BLOCK = 8'h50;
   localparam logic [7:0] OP_ERASE_SECTOR = 8'h7C;
   localparam logic [7:0] OP_ERASE_CHIP = 8'hC7;
   localparam logic [7:0] OP_SEC_WR = 8'h9B;
   localparam logic [7:0] OP_SEC_RD = 8'h77;
   localparam logic [7:0] OP_CONFIG = 8'h3D;
   localparam logic [7:0] CFG_BIN = 8'hA6;
   localparam logic [7:0] CFG_STD = 8'hA7;
   localparam logic [2:0] ADDR_DONE_CNT = 3'h4;
   localparam logic [2:0] CFG_DONE_CNT = 3'h2;
   localparam logic [2:0] TX_LOAD_BIT = 3'h4;
   typedef enum logic [1:0] {BG_IDLE, BG_PROG, BG_XFER, BG_ERASE} sfhi_bg_t;
endpackage

// [core/sfhi_link_if.sv]
// Byte channel between the serial-clock shifter and the command engine.
// Assumes rxByte stays stable for a whole byte time after rxToggle flips.
`timescale 1ns/1ps
interface sfhi_link_if;
   logic [7:0] rxByte;
   logic rxToggle;
   logic [7:0] txByte;
   modport link (output rxByte, output rxToggle, input txByte);
   modport core (input rxByte, input rxToggle, output txByte);
endinterface

// [core/sfhi_link.sv]
// Serial-clock domain shifter: receive and transmit shift registers.
// Assumes chip select high clears the frame state; rst only clears the toggle.
`timescale 1ns/1ps
module sfhi_link (
   input wire logic sck,
   input wire logic csN,
   input wire logic si,
   input wire logic rst,
   output logic soData,
   sfhi_link_if.link lnk
);
   typedef struct packed {
      logic [2:0] bitCnt;
      logic [6:0] shift;
      logic [7:0] rxByte;
   } sfhi_rx_t;
   typedef struct packed {
      logic [7:0] hold;
      logic [7:0] shift;
   } sfhi_tx_t;

   sfhi_rx_t rx_reg;
   sfhi_rx_t rx_next;
   sfhi_tx_t tx_reg;
   sfhi_tx_t tx_next;
   logic toggle_reg;

   always_comb begin
      rx_next = rx_reg;
      rx_next.bitCnt = rx_reg.bitCnt + 3'h1;
      if (rx_reg.bitCnt == 3'h7) begin
         rx_next.rxByte = {rx_reg.shift, si};
      end else begin
         rx_next.shift = {rx_reg.shift[5:0], si};
      end
      tx_next = tx_reg;
      if (rx_reg.bitCnt == sfhi_pkg::TX_LOAD_BIT) begin
         tx_next.hold = lnk.txByte;
      end
      // A falling edge right after a byte boundary presents the next MSB.
      if (rx_reg.bitCnt == 3'h0) begin
         tx_next.shift = tx_reg.hold;
      end else begin
         tx_next.shift = {tx_reg.shift[6:0], 1'b1};
      end
   end

   always_ff @(posedge sck or posedge csN) begin
      if (csN) begin
         rx_reg <= '0;
      end else begin
         rx_reg <= rx_next;
      end
   end

   always_ff @(negedge sck or posedge csN) begin
      if (csN) begin
         tx_reg <= {sfhi_pkg::FILL_BYTE, sfhi_pkg::FILL_BYTE};
      end else begin
         tx_reg <= tx_next;
      end
   end

   // The toggle survives deselection so the engine never sees a false byte.
   always_ff @(posedge sck or posedge rst) begin
      if (rst) begin
         toggle_reg <= 1'b0;
      end else if (rx_reg.bitCnt == 3'h7) begin
         toggle_reg <= ~toggle_reg;
      end
   end

   assign soData = tx_reg.shift[7];
   assign lnk.rxByte = rx_reg.rxByte;
   assign lnk.rxToggle = toggle_reg;
endmodule // sfhi_link

// [core/sfhi_top.sv]
// Command engine of the serial flash front end, two page buffers and security area.
// Assumes an external array macro whose arrRdData shows the addressed byte combinationally,
// and a system clock at least five times the serial clock.
`timescale 1ns/1ps
module sfhi_top #(
   parameter logic [7:0] MFR_ID = 8'h5A, // Arbitrary value.
   parameter logic [7:0] DEV_ID = 8'hC3, // Arbitrary value.
   parameter logic [511:0] UNIQUE_ID = 512'hA5, // Arbitrary value.
   parameter logic [sfhi_pkg::SECTOR_COUNT-1:0] PROTECT_MASK = 16'h0000,
   parameter logic DEFAULT_BIN_PAGE = 1'b0
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic csN,
   input wire logic sck,
   input wire logic si,
   output logic soOut,
   output logic soOe,
   input wire logic resetN,
   input wire logic wpN,
   output logic rdyOut,
   output logic rdyOe,
   output logic [11:0] arrPage,
   output logic [9:0] arrByte,
   output logic [7:0] arrWrData,
   output logic arrWrite,
   input wire logic [7:0] arrRdData
);
   typedef struct packed {
      logic [2:0] csSync;
      logic csFilt;
      logic [2:0] rstSync;
      logic rstFilt;
      logic [2:0] wpSync;
      logic wpFilt;
      logic [2:0] togSync;
      logic togFilt;
      logic [2:0] byteCnt;
      logic [7:0] opcode;
      logic [23:0] addr;
      logic [9:0] ptr;
      logic [7:0] txByte;
      logic binPage;
      sfhi_pkg::sfhi_bg_t bg;
      logic bgBuf;
      logic [11:0] bgPage;
      logic [12:0] pagesLeft;
      logic [9:0] idx;
      logic rdPend;
      logic [11:0] arrPage;
      logic [9:0] arrByte;
      logic [7:0] arrWd;
      logic arrWr;
   } sfhi_state_t;

   sfhi_state_t s_reg;
   sfhi_state_t s_next;
   logic [7:0] bufMem [0:1][0:sfhi_pkg::BUF_BYTES-1];
   logic [7:0] secMem [0:sfhi_pkg::SEC_USER_BYTES-1];
   logic bufWe;
   logic bufWeSel;
   logic [9:0] bufWeIdx;
   logic [7:0] bufWeData;
   logic secWe;
   logic [5:0] secWeIdx;
   logic [7:0] secWeData;
   logic byteEv;
   logic csRise;
   logic csFall;
   logic [7:0] rxB;
   logic [7:0] op;
   logic [2:0] k;
   logic [23:0] fullAddr;
   logic [9:0] p;
   logic [9:0] lastIdx;
   logic [11:0] pg;
   logic sel;
   logic [7:0] statusByte;

   sfhi_link_if lnk ();

   sfhi_link uLink (
      .sck(sck),
      .csN(csN),
      .si(si),
      .rst(rst),
      .soData(soOut),
      .lnk(lnk)
   );

   function automatic logic [9:0] byteOf(logic [23:0] a, logic bin);
      return bin ? {1'b0, a[8:0]} : a[9:0];
   endfunction

   function automatic logic [11:0] pageOf(logic [23:0] a, logic bin);
      return bin ? a[20:9] : a[21:10];
   endfunction

   function automatic logic [9:0] ptrInc(logic [9:0] v, logic [9:0] last);
      return (v == last) ? 10'h000 : v + 10'h001;
   endfunction

   function automatic logic protHit(logic [11:0] page, logic wpHigh);
      return !wpHigh && PROTECT_MASK[page[11:8]];
   endfunction

   function automatic logic [7:0] secByte(logic [6:0] a, logic [7:0] user);
      return a[6] ? UNIQUE_ID[{a[5:0], 3'h0} +: 8] : user;
   endfunction

   function automatic logic bufBusy(logic b, sfhi_pkg::sfhi_bg_t bg, logic bgBuf);
      return (bg == sfhi_pkg::BG_PROG || bg == sfhi_pkg::BG_XFER) && bgBuf == b;
   endfunction

   always_comb begin
      s_next = s_reg;
      bufWe = 1'b0;
      bufWeSel = 1'b0;
      bufWeIdx = 10'h000;
      bufWeData = 8'h00;
      secWe = 1'b0;
      secWeIdx = 6'h00;
      secWeData = 8'h00;
      rxB = lnk.rxByte;
      k = s_reg.byteCnt;
      op = (k == 3'h0) ? rxB : s_reg.opcode;
      fullAddr = {s_reg.addr[15:0], rxB};
      p = s_reg.ptr;
      sel = 1'b0;
      pg = 12'h000;
      lastIdx = s_reg.binPage ? sfhi_pkg::PAGE_LAST_BIN : sfhi_pkg::PAGE_LAST_STD;
      statusByte = 8'h00;
      statusByte[sfhi_pkg::STAT_READY_BIT] = s_reg.bg == sfhi_pkg::BG_IDLE;
      statusByte[sfhi_pkg::STAT_PROT_BIT] = !s_reg.wpFilt;
      statusByte[sfhi_pkg::STAT_BIN_BIT] = s_reg.binPage;
      // Pins and the byte toggle pass three flops; the last two must agree.
      s_next.csSync = {s_reg.csSync[1:0], csN};
      s_next.rstSync = {s_reg.rstSync[1:0], resetN};
      s_next.wpSync = {s_reg.wpSync[1:0], wpN};
      s_next.togSync = {s_reg.togSync[1:0], lnk.rxToggle};
      if (s_reg.csSync[1] == s_reg.csSync[2]) begin
         s_next.csFilt = s_reg.csSync[2];
      end
      if (s_reg.rstSync[1] == s_reg.rstSync[2]) begin
         s_next.rstFilt = s_reg.rstSync[2];
      end
      if (s_reg.wpSync[1] == s_reg.wpSync[2]) begin
         s_next.wpFilt = s_reg.wpSync[2];
      end
      if (s_reg.togSync[1] == s_reg.togSync[2]) begin
         s_next.togFilt = s_reg.togSync[2];
      end
      byteEv = s_next.togFilt != s_reg.togFilt;
      csFall = s_reg.csFilt && !s_next.csFilt;
      csRise = !s_reg.csFilt && s_next.csFilt;
      s_next.arrWr = 1'b0;
      s_next.rdPend = 1'b0;

      if (!s_reg.rstFilt) begin
         s_next.bg = sfhi_pkg::BG_IDLE;
         s_next.byteCnt = 3'h0;
         s_next.opcode = 8'h00;
         s_next.idx = 10'h000;
         s_next.txByte = sfhi_pkg::FILL_BYTE;
      end else begin
         // Background engine walks one byte per clock.
         case (s_reg.bg)
            sfhi_pkg::BG_PROG: begin
               s_next.arrPage = s_reg.bgPage;
               s_next.arrByte = s_reg.idx;
               s_next.arrWd = bufMem[s_reg.bgBuf][s_reg.idx];
               s_next.arrWr = 1'b1;
               s_next.idx = ptrInc(s_reg.idx, lastIdx);
               if (s_reg.idx == lastIdx) begin
                  s_next.bg = sfhi_pkg::BG_IDLE;
               end
            end
            sfhi_pkg::BG_XFER: begin
               s_next.arrPage = s_reg.bgPage;
               s_next.arrByte = s_reg.idx;
               s_next.rdPend = 1'b1;
               s_next.idx = ptrInc(s_reg.idx, lastIdx);
               if (s_reg.idx == lastIdx) begin
                  s_next.bg = sfhi_pkg::BG_IDLE;
               end
            end
            sfhi_pkg::BG_ERASE: begin
               s_next.arrPage = s_reg.bgPage;
               s_next.arrByte = s_reg.idx;
               s_next.arrWd = sfhi_pkg::FILL_BYTE;
               s_next.arrWr = 1'b1;
               s_next.idx = ptrInc(s_reg.idx, lastIdx);
               if (s_reg.idx == lastIdx) begin
                  s_next.bgPage = s_reg.bgPage + 12'h001;
                  s_next.pagesLeft = s_reg.pagesLeft - 13'h0001;
                  if (s_reg.pagesLeft == 13'h0001) begin
                     s_next.bg = sfhi_pkg::BG_IDLE;
                  end
               end
            end
            default: ;
         endcase

         if (csFall) begin
            s_next.byteCnt = 3'h0;
            s_next.txByte = sfhi_pkg::FILL_BYTE;
         end

         if (byteEv && !s_reg.csFilt) begin
            if (k != 3'h7) begin
               s_next.byteCnt = k + 3'h1;
            end
            if (k == 3'h0) begin
               s_next.opcode = rxB;
            end else if (k <= 3'h3) begin
               s_next.addr = fullAddr;
            end
            // A reply prepared now leaves the device two bytes later.
            case (op)
               sfhi_pkg::OP_STATUS: s_next.txByte = statusByte;
               sfhi_pkg::OP_ID: begin
                  if (k == 3'h0) begin
                     s_next.txByte = MFR_ID;
                  end else if (k == 3'h1) begin
                     s_next.txByte = DEV_ID;
                  end else begin
                     s_next.txByte = sfhi_pkg::FILL_BYTE;
                  end
               end
               sfhi_pkg::OP_BUF1_RD, sfhi_pkg::OP_BUF2_RD: begin
                  if (k >= 3'h3) begin
                     sel = op == sfhi_pkg::OP_BUF2_RD;
                     p = (k == 3'h3) ? byteOf(fullAddr, s_reg.binPage) : s_reg.ptr;
                     s_next.txByte = bufBusy(sel, s_reg.bg, s_reg.bgBuf) ?
                        sfhi_pkg::FILL_BYTE : bufMem[sel][p];
                     s_next.ptr = ptrInc(p, lastIdx);
                  end
               end
               sfhi_pkg::OP_SEC_RD: begin
                  if (k >= 3'h3) begin
                     p = (k == 3'h3) ? {3'h0, fullAddr[6:0]} : s_reg.ptr;
                     s_next.txByte = secByte(p[6:0], secMem[p[5:0]]);
                     s_next.ptr = {3'h0, p[6:0] + 7'h01};
                  end
               end
               sfhi_pkg::OP_BUF1_WR, sfhi_pkg::OP_BUF2_WR: begin
                  sel = op == sfhi_pkg::OP_BUF2_WR;
                  if (k == 3'h3) begin
                     s_next.ptr = byteOf(fullAddr, s_reg.binPage);
                  end else if (k >= sfhi_pkg::ADDR_DONE_CNT) begin
                     bufWe = !bufBusy(sel, s_reg.bg, s_reg.bgBuf);
                     bufWeSel = sel;
                     bufWeIdx = s_reg.ptr;
                     bufWeData = rxB;
                     s_next.ptr = ptrInc(s_reg.ptr, lastIdx);
                  end
               end
               sfhi_pkg::OP_SEC_WR: begin
                  if (k == 3'h3) begin
                     s_next.ptr = 10'h000;
                  end else if (k >= sfhi_pkg::ADDR_DONE_CNT &&
                               s_reg.ptr < sfhi_pkg::SEC_USER_BYTES) begin
                     secWe = 1'b1;
                     secWeIdx = s_reg.ptr[5:0];
                     secWeData = rxB;
                     s_next.ptr = s_reg.ptr + 10'h001;
                  end
               end
               default: ;
            endcase
         end

         // Deselect commits the command; the work then runs on its own.
         if (csRise && s_reg.bg == sfhi_pkg::BG_IDLE) begin
            pg = pageOf(s_next.addr, s_reg.binPage);
            s_next.idx = 10'h000;
            s_next.bgBuf = s_next.opcode == sfhi_pkg::OP_PROG2 ||
                           s_next.opcode == sfhi_pkg::OP_XFER2;
            case (s_next.opcode)
               sfhi_pkg::OP_PROG1, sfhi_pkg::OP_PROG2: begin
                  if (s_next.byteCnt >= sfhi_pkg::ADDR_DONE_CNT &&
                      !protHit(pg, s_reg.wpFilt)) begin
                     s_next.bg = sfhi_pkg::BG_PROG;
                     s_next.bgPage = pg;
                  end
               end
               sfhi_pkg::OP_XFER1, sfhi_pkg::OP_XFER2: begin
                  if (s_next.byteCnt >= sfhi_pkg::ADDR_DONE_CNT) begin
                     s_next.bg = sfhi_pkg::BG_XFER;
                     s_next.bgPage = pg;
                  end
               end
               sfhi_pkg::OP_ERASE_PAGE, sfhi_pkg::OP_ERASE_BLOCK,
               sfhi_pkg::OP_ERASE_SECTOR: begin
                  if (s_next.byteCnt >= sfhi_pkg::ADDR_DONE_CNT &&
                      !protHit(pg, s_reg.wpFilt)) begin
                     s_next.bg = sfhi_pkg::BG_ERASE;
                     if (s_next.opcode == sfhi_pkg::OP_ERASE_PAGE) begin
                        s_next.bgPage = pg;
                        s_next.pagesLeft = sfhi_pkg::PAGES_PAGE;
                     end else if (s_next.opcode == sfhi_pkg::OP_ERASE_BLOCK) begin
                        s_next.bgPage = pg & sfhi_pkg::BLOCK_PAGE_MASK;
                        s_next.pagesLeft = sfhi_pkg::PAGES_BLOCK;
                     end else begin
                        s_next.bgPage = pg & sfhi_pkg::SECTOR_PAGE_MASK;
                        s_next.pagesLeft = sfhi_pkg::PAGES_SECTOR;
                     end
                  end
               end
               sfhi_pkg::OP_ERASE_CHIP: begin
                  if (s_next.byteCnt != 3'h0 && !(!s_reg.wpFilt && |PROTECT_MASK)) begin
                     s_next.bg = sfhi_pkg::BG_ERASE;
                     s_next.bgPage = 12'h000;
                     s_next.pagesLeft = sfhi_pkg::PAGES_CHIP;
                  end
               end
               sfhi_pkg::OP_CONFIG: begin
                  if (s_next.byteCnt >= sfhi_pkg::CFG_DONE_CNT) begin
                     if (s_next.addr[7:0] == sfhi_pkg::CFG_BIN) begin
                        s_next.binPage = 1'b1;
                     end else if (s_next.addr[7:0] == sfhi_pkg::CFG_STD) begin
                        s_next.binPage = 1'b0;
                     end
                  end
               end
               default: ;
            endcase
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s_reg <= '0;
         s_reg.csSync <= 3'h7;
         s_reg.csFilt <= 1'b1;
         s_reg.rstSync <= 3'h7;
         s_reg.rstFilt <= 1'b1;
         s_reg.wpSync <= 3'h7;
         s_reg.wpFilt <= 1'b1;
         s_reg.txByte <= sfhi_pkg::FILL_BYTE;
         s_reg.binPage <= DEFAULT_BIN_PAGE;
         s_reg.bg <= sfhi_pkg::BG_IDLE;
      end else begin
         s_reg <= s_next;
      end
   end

   // Buffer and security storage; a transfer read lands one clock after its address.
   always_ff @(posedge clk) begin
      if (bufWe) begin
         bufMem[bufWeSel][bufWeIdx] <= bufWeData;
      end
      if (s_reg.rdPend) begin
         bufMem[s_reg.bgBuf][s_reg.arrByte] <= arrRdData;
      end
      if (secWe) begin
         secMem[secWeIdx] <= secWeData;
      end
   end

   assign lnk.txByte = s_reg.txByte;
   assign soOe = !csN;
   assign rdyOut = 1'b0;
   // The final array write or buffer fill still counts as busy.
   assign rdyOe = s_reg.bg != sfhi_pkg::BG_IDLE || s_reg.arrWr || s_reg.rdPend;
   assign arrPage = s_reg.arrPage;
   assign arrByte = s_reg.arrByte;
   assign arrWrData = s_reg.arrWd;
   assign arrWrite = s_reg.arrWr;
endmodule // sfhi_top

// [verif/sfhi_monitor.sv]
// Port checker of the serial flash front end.
// Assumes it is bound to sfhi_top and sees only its ports.
`timescale 1ns/1ps
module sfhi_monitor (
   input wire logic clk,
   input wire logic rst,
   input wire logic csN,
   input wire logic sck,
   input wire logic si,
   input wire logic soOut,
   input wire logic soOe,
   input wire logic resetN,
   input wire logic wpN,
   input wire logic rdyOut,
   input wire logic rdyOe,
   input wire logic [11:0] arrPage,
   input wire logic [9:0] arrByte,
   input wire logic [7:0] arrWrData,
   input wire logic arrWrite,
   input wire logic [7:0] arrRdData
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   a_oe_follows_cs: assert property (soOe == !csN) else $error("SO enable wrong");
   a_rdy_drain_low: assert property (rdyOut == 1'b0) else $error("ready pin drives high");
   a_write_while_busy: assert property (arrWrite |-> rdyOe) else $error("write while idle");
   a_busy_after_deselect: assert property ($rose(rdyOe) |-> $past(csN, 2))
      else $error("busy began inside a frame");
   a_pin_reset_idle: assert property ((!resetN) [*8] |-> !rdyOe)
      else $error("busy during reset pin");
   a_reset_quiet: assert property ($fell(rst) |-> !rdyOe && !arrWrite) else $error("not idle");
   a_byte_walk: assert property (arrWrite && $past(arrWrite)
      |-> arrByte == $past(arrByte) + 10'h001 || arrByte == 10'h000) else $error("byte skip");
   a_page_steady: assert property (arrWrite && $past(arrWrite) && arrByte != 10'h000
      |-> $stable(arrPage)) else $error("page moved inside page");
   a_byte_range: assert property (arrWrite |-> arrByte <= sfhi_pkg::PAGE_LAST_STD)
      else $error("byte beyond page");
   a_so_on_fall: assert property (sck && $past(sck) && !csN && !$past(csN) |-> $stable(soOut))
      else $error("SO moved while clock high");
endmodule // sfhi_monitor
bind sfhi_top sfhi_monitor i_mon (.clk(clk), .rst(rst), .csN(csN), .sck(sck), .si(si),
   .soOut(soOut), .soOe(soOe), .resetN(resetN), .wpN(wpN), .rdyOut(rdyOut), .rdyOe(rdyOe),
   .arrPage(arrPage), .arrByte(arrByte), .arrWrData(arrWrData), .arrWrite(arrWrite),
   .arrRdData(arrRdData));

// [verif/sfhi_host_model.sv]
// Behavioural SPI host that frames transfers to the flash front end.
// Assumes a 64 ns serial clock inside frames; the noise task runs it at 32 ns between frames.
`timescale 1ns/1ps
module sfhi_host_model (
   input wire logic mode3,
   input wire logic soPin,
   output logic csN,
   output logic sck,
   output logic si
);
   initial begin
      csN = 1'b1;
      sck = 1'b0;
      si = 1'b0;
   end
   task automatic noise(input logic [7:0] v);
      for (int i = 7; i >= 0; i--) begin
         si = v[i];
         sck = 1'b1;
         #16;
         sck = 1'b0;
         #16;
      end
   endtask
   task automatic begin_f();
      sck = mode3;
      #32;
      csN = 1'b0;
      #32;
   endtask
   task automatic xb(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         sck = 1'b0;
         si = tx[i];
         #32;
         sck = 1'b1;
         rx[i] = soPin;
         #32;
      end
   endtask
   task automatic end_f();
      sck = mode3;
      #32;
      csN = 1'b1;
      si = !si;
      #200;
   endtask
endmodule // sfhi_host_model

// [verif/tb_top.sv]
// Self-checking bench of the serial flash front end.
// Assumes an array macro whose read data is page xor byte.
`timescale 1ns/1ps
module tb_top;
   logic clk = 1'b0, rst = 1'b0, resetN = 1'b1, wpN = 1'b1, mode3 = 1'b0, soLast = 1'b0;
   logic csN, sck, si, soOut, soOe, rdyOut, rdyOe, arrWrite;
   logic [11:0] arrPage;
   logic [9:0] arrByte;
   logic [7:0] arrWrData, arrRdData, rx;
   logic [7:0] bufImg [528];
   logic [7:0] expQ [$], gotQ [$];
   logic [29:0] wrQ [$];
   int err_total = 0, check_count = 0, cyc = 0, seed = 32'h406d;
   wire soPin = soOe ? soOut : !soLast;
   assign arrRdData = arrPage[7:0] ^ arrByte[7:0];
   always @(soOut or soOe) if (soOe) soLast = soOut;
   initial forever #5 clk = ~clk;
   sfhi_top #(.PROTECT_MASK(16'h0001)) i_dut (.clk(clk), .rst(rst), .csN(csN), .sck(sck),
      .si(si), .soOut(soOut), .soOe(soOe), .resetN(resetN), .wpN(wpN), .rdyOut(rdyOut),
      .rdyOe(rdyOe), .arrPage(arrPage), .arrByte(arrByte), .arrWrData(arrWrData),
      .arrWrite(arrWrite), .arrRdData(arrRdData));
   sfhi_host_model i_host (.mode3(mode3), .soPin(soPin), .csN(csN), .sck(sck), .si(si));
   task automatic tally(input logic ok, input logic [29:0] g, input logic [29:0] e);
      check_count++;
      if (!ok) begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic cmp_byte(input logic [7:0] g, input logic [7:0] e);
      tally(g === e, {22'h0, g}, {22'h0, e});
   endtask
   task automatic cmp_write(input logic [29:0] g, input logic [29:0] e);
      tally(g === e, g, e);
   endtask
   task automatic final_report();
      $display("checks %0d errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic note(input logic [7:0] g, input logic [7:0] e);
      expQ.push_back(e);
      gotQ.push_back(g);
   endtask
   task automatic xb(input logic [7:0] tx, input bit chk, input logic [7:0] e);
      i_host.xb(tx, rx);
      if (chk) note(rx, e);
   endtask
   task automatic cmd(input logic [7:0] op, input logic [11:0] pg, input logic [9:0] by);
      logic [23:0] a;
      a = {2'h0, pg, by};
      i_host.begin_f();
      xb(op, 0, 8'h00);
      xb(a[23:16], 0, 8'h00);
      xb(a[15:8], 0, 8'h00);
      xb(a[7:0], 0, 8'h00);
   endtask
   task automatic wait_done();
      repeat (10) @(negedge clk);
      for (int i = 0; i < 6000 && rdyOe !== 1'b0; i++) @(negedge clk);
      note({7'h0, rdyOe}, 8'h00);
   endtask
   task automatic id_read();
      i_host.noise(8'($random(seed)));
      i_host.begin_f();
      xb(sfhi_pkg::OP_ID, 0, 8'h00);
      xb(8'h00, 0, 8'h00);
      xb(8'h00, 1, 8'h5A);
      xb(8'h00, 1, 8'hC3);
      xb(8'h00, 1, sfhi_pkg::FILL_BYTE);
      i_host.end_f();
   endtask
   task automatic status_rd(input logic [7:0] e);
      i_host.begin_f();
      xb(sfhi_pkg::OP_STATUS, 0, 8'h00);
      xb(8'h00, 0, 8'h00);
      xb(8'h00, 1, e);
      i_host.end_f();
   endtask
   initial forever begin
      @(posedge clk);
      if (gotQ.size() > 0) cmp_byte(gotQ.pop_front(), expQ.pop_front());
   end
   always @(negedge clk) begin
      cyc++;
      if (arrWrite === 1'b1)
         cmp_write({arrPage, arrByte, arrWrData}, wrQ.size() > 0 ? wrQ.pop_front() : '1);
      if (cyc == 60000) begin
         err_total++;
         final_report();
      end
   end
   initial begin
      logic [7:0] d;
      // A real rising edge is needed to clear the serial-clock byte toggle.
      #1 rst = 1'b1;
      repeat (3) @(negedge clk);
      rst = 1'b0;
      repeat (10) @(negedge clk);
      for (int m = 0; m < 2; m++) begin
         mode3 = m[0];
         id_read();
      end
      status_rd(8'h80);
      cmd(sfhi_pkg::OP_SEC_WR, 12'h000, 10'h000);
      xb(8'h3C, 0, 8'h00);
      i_host.end_f();
      cmd(sfhi_pkg::OP_SEC_RD, 12'h000, 10'h07F);
      xb(8'h00, 0, 8'h00);
      xb(8'h00, 1, 8'h00);
      xb(8'h00, 1, 8'h3C);
      i_host.end_f();
      cmd(sfhi_pkg::OP_XFER1, 12'h005, 10'h000);
      i_host.end_f();
      wait_done();
      for (int b = 0; b < 528; b++) bufImg[b] = 8'h05 ^ b[7:0];
      cmd(sfhi_pkg::OP_BUF1_WR, 12'h000, 10'h20E);
      for (int k = 0; k < 4; k++) begin
         d = 8'($random(seed));
         bufImg[(526 + k) % 528] = d;
         xb(d, 0, 8'h00);
      end
      i_host.end_f();
      cmd(sfhi_pkg::OP_BUF1_RD, 12'h000, 10'h20D);
      xb(8'h00, 0, 8'h00);
      for (int k = 0; k < 6; k++) xb(8'h00, 1, bufImg[(525 + k) % 528]);
      i_host.end_f();
      for (int b = 0; b < 528; b++) wrQ.push_back({12'h009, b[9:0], bufImg[b]});
      cmd(sfhi_pkg::OP_PROG1, 12'h009, 10'h000);
      i_host.end_f();
      repeat (10) @(negedge clk);
      note({7'h0, rdyOe}, 8'h01);
      cmd(sfhi_pkg::OP_BUF2_WR, 12'h000, 10'h000);
      xb(8'hA5, 0, 8'h00);
      i_host.end_f();
      cmd(sfhi_pkg::OP_BUF2_RD, 12'h000, 10'h000);
      xb(8'h00, 0, 8'h00);
      xb(8'h00, 1, 8'hA5);
      i_host.end_f();
      wait_done();
      wpN = 1'b0;
      cmd(sfhi_pkg::OP_ERASE_PAGE, 12'h003, 10'h000);
      i_host.end_f();
      repeat (20) @(negedge clk);
      note({7'h0, rdyOe}, 8'h00);
      status_rd(8'h82);
      wpN = 1'b1;
      repeat (8) @(negedge clk);
      for (int k = 0; k < 2; k++) begin
         for (int p = 0; p < (k ? 8 : 1); p++)
            for (int b = 0; b < 528; b++) wrQ.push_back({12'(k ? p : 3), b[9:0], 8'hFF});
         cmd(k ? sfhi_pkg::OP_ERASE_BLOCK : sfhi_pkg::OP_ERASE_PAGE, 12'h003, 10'h000);
         i_host.end_f();
         if (k) status_rd(8'h00);
         wait_done();
      end
      for (int b = 0; b < 528; b++) wrQ.push_back({12'h009, b[9:0], bufImg[b]});
      cmd(sfhi_pkg::OP_PROG1, 12'h009, 10'h000);
      i_host.end_f();
      repeat (40) @(negedge clk);
      resetN = 1'b0;
      repeat (20) @(negedge clk);
      note({7'h0, rdyOe}, 8'h00);
      wrQ.delete();
      resetN = 1'b1;
      repeat (10) @(negedge clk);
      id_read();
      repeat (10) @(negedge clk);
      cmp_write(30'(wrQ.size()), 30'h0);
      final_report();
   end
endmodule // tb_top
